// ==== logic/nsd_pkg.sv ====
// package: constants and types for the nibble swap / direction load executor
package nsd_pkg;
    // quarter-cycle phase codes, one-hot
    typedef enum logic [3:0] {
        NSD_Q1 = 4'b0001,
        NSD_Q2 = 4'b0010,
        NSD_Q3 = 4'b0100,
        NSD_Q4 = 4'b1000
    } nsd_phase_t;
    localparam int NSD_QUARTERS = 4;
    localparam logic [7:0] NSD_WREG_RST = 8'h00;
    localparam logic [7:0] NSD_DIR_RST = 8'hFF;
    localparam logic [4:0] NSD_FADDR_RST = 5'h00;
    localparam logic [11:0] NSD_IR_RST = 12'h000;
    localparam logic [7:0] NSD_FWDATA_RST = 8'h00;
    localparam logic [2:0] NSD_FLAGS_RST = 3'h0;
    localparam int NSD_LO_NIB = 0;
    localparam int NSD_HI_NIB = 4;
    localparam logic [2:0] NSD_DIR_FIRST = 3'h5;
    localparam logic [2:0] NSD_DIR_LAST = 3'h7;
    localparam int NSD_DIR_COUNT = 3;
    localparam logic [11:0] NSD_SWAP_MASK = 12'hFC0;
    localparam logic [11:0] NSD_SWAP_CODE = 12'h380;
    localparam logic [11:0] NSD_DIRL_MASK = 12'hFF8;
    localparam logic [11:0] NSD_DIRL_CODE = 12'h000;
    localparam int NSD_DBIT = 5;
endpackage

// ==== logic/nsd_phase_gen.sv ====
// module: four-quarter instruction cycle sequencer
`timescale 1ns/1ps
module nsd_phase_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // phase
    output nsd_pkg::nsd_phase_t phase_out
);
    typedef struct packed {
        nsd_pkg::nsd_phase_t phase;
    } nsd_pg_state_t;
    nsd_pg_state_t st_ff;
    nsd_pg_state_t nxt_st;
    // rotate one quarter per oscillator period
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.phase)
            nsd_pkg::NSD_Q1: nxt_st.phase = nsd_pkg::NSD_Q2; // see RULE5
            nsd_pkg::NSD_Q2: nxt_st.phase = nsd_pkg::NSD_Q3;
            nsd_pkg::NSD_Q3: nxt_st.phase = nsd_pkg::NSD_Q4;
            nsd_pkg::NSD_Q4: nxt_st.phase = nsd_pkg::NSD_Q1;
            default: nxt_st.phase = nsd_pkg::NSD_Q1;
        endcase
    end
    // state register
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            st_ff.phase <= nsd_pkg::NSD_Q1;
        else
            st_ff <= nxt_st;
    end
    assign phase_out = st_ff.phase;
endmodule // nsd_phase_gen

// ==== logic/nsd_exec.sv ====
// module: execution of the nibble swap and direction load instructions
// Contract
// RULE1: the swap result takes source bits 3..0 into bits 7..4 and bits 7..4 into bits 3..0.
// RULE2: with the destination bit at 0 the swap result goes to the working register only.
// RULE3: with the destination bit at 1 the swap result goes back to the source file register.
// RULE4: direction load copies the whole working register into direction register 5, 6 or 7.
// RULE5: each instruction cycle lasts exactly four clock periods.
// RULE6: neither instruction touches the zero, digit carry or carry flags; each takes one cycle.
`timescale 1ns/1ps
module nsd_exec (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // instruction word, sampled at the clock edge that ends Q1
    input wire logic [11:0] instr_in,
    // file register read data for the addressed operand
    input wire logic [7:0] file_rdata_in,
    // status flags from the core (z, dc, c)
    input wire logic [2:0] flags_in,
    // file register write port
    output logic file_we_out,
    output logic [4:0] file_addr_out,
    output logic [7:0] file_wdata_out,
    // working register and direction registers
    output logic [7:0] wreg_out,
    output logic [7:0] dir_a_out,
    output logic [7:0] dir_b_out,
    output logic [7:0] dir_c_out,
    // flags passed through unchanged, and cycle marker
    output logic [2:0] flags_out,
    output logic done_out
);
    nsd_pkg::nsd_phase_t phase;
    typedef struct packed {
        logic [11:0] ir;
        logic [7:0] wreg;
        logic [2:0][7:0] dir;
        logic fwe;
        logic [4:0] faddr;
        logic [7:0] fwdata;
        logic [2:0] flags;
        logic done;
    } nsd_state_t;
    nsd_state_t st_ff;
    nsd_state_t nxt_st;
    logic is_swap;
    logic is_dirl;
    logic [7:0] swapped;
    logic [2:0] dsel;
    // next value of each direction register, one driver per entry
    wire logic [2:0][7:0] dir_nxt;

    // quarter sequencer
    nsd_phase_gen u_phase (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(phase)
    );

    // decode and datapath
    assign is_swap = (st_ff.ir & nsd_pkg::NSD_SWAP_MASK) == nsd_pkg::NSD_SWAP_CODE;
    assign dsel = st_ff.ir[2:0];
    assign is_dirl = ((st_ff.ir & nsd_pkg::NSD_DIRL_MASK) == nsd_pkg::NSD_DIRL_CODE)
        && (dsel >= nsd_pkg::NSD_DIR_FIRST) && (dsel <= nsd_pkg::NSD_DIR_LAST);
    assign swapped = {file_rdata_in[nsd_pkg::NSD_LO_NIB +: 4],
                      file_rdata_in[nsd_pkg::NSD_HI_NIB +: 4]}; // see RULE1

    // next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.fwe = 1'b0;
        nxt_st.done = 1'b0;
        nxt_st.flags = flags_in; // see RULE6
        nxt_st.dir = dir_nxt; // see RULE4
        case (phase)
            nsd_pkg::NSD_Q1: nxt_st.ir = instr_in;
            nsd_pkg::NSD_Q2: nxt_st.faddr = st_ff.ir[4:0];
            nsd_pkg::NSD_Q3: ;
            nsd_pkg::NSD_Q4:
            begin
                nxt_st.done = 1'b1; // see RULE6
                if (is_swap && !st_ff.ir[nsd_pkg::NSD_DBIT])
                    nxt_st.wreg = swapped; // see RULE2
                if (is_swap && st_ff.ir[nsd_pkg::NSD_DBIT])
                begin
                    nxt_st.fwe = 1'b1; // see RULE3
                    nxt_st.fwdata = swapped;
                end
            end
            default: ;
        endcase
    end

    // direction registers, one per selectable port: load on a decoded selector, else hold
    for (genvar i = 0; i < nsd_pkg::NSD_DIR_COUNT; i++)
    begin : g_dir
        assign dir_nxt[i] = (phase == nsd_pkg::NSD_Q4 && is_dirl
                             && dsel == nsd_pkg::NSD_DIR_FIRST + 3'(i))
            ? st_ff.wreg : st_ff.dir[i]; // see RULE4
    end

    // state register, the only process that writes st_ff
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_ff.ir <= nsd_pkg::NSD_IR_RST;
            st_ff.wreg <= nsd_pkg::NSD_WREG_RST;
            st_ff.dir <= {nsd_pkg::NSD_DIR_COUNT{nsd_pkg::NSD_DIR_RST}};
            st_ff.fwe <= 1'b0;
            st_ff.faddr <= nsd_pkg::NSD_FADDR_RST;
            st_ff.fwdata <= nsd_pkg::NSD_FWDATA_RST;
            st_ff.flags <= nsd_pkg::NSD_FLAGS_RST;
            st_ff.done <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from flops
    assign file_we_out = st_ff.fwe;
    assign file_addr_out = st_ff.faddr;
    assign file_wdata_out = st_ff.fwdata;
    assign wreg_out = st_ff.wreg;
    assign dir_a_out = st_ff.dir[0];
    assign dir_b_out = st_ff.dir[1];
    assign dir_c_out = st_ff.dir[2];
    assign flags_out = st_ff.flags;
    assign done_out = st_ff.done;

    // checks
    sequence s_q4_swap_to_w;
        phase == nsd_pkg::NSD_Q4 && is_swap && !st_ff.ir[nsd_pkg::NSD_DBIT];
    endsequence
    a_swap_to_w: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE2
        s_q4_swap_to_w |=> wreg_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])}
            && !file_we_out)
        else $error("swap to working register wrong");
    a_swap_to_f: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE3
        phase == nsd_pkg::NSD_Q4 && is_swap && st_ff.ir[nsd_pkg::NSD_DBIT]
        |=> file_we_out && file_wdata_out == {$past(file_rdata_in[3:0]),
            $past(file_rdata_in[7:4])} && $stable(wreg_out))
        else $error("swap to file register wrong");
    a_swap_nibbles: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE1
        file_we_out |-> file_wdata_out[7:4] == $past(file_rdata_in[3:0])
            && file_wdata_out[3:0] == $past(file_rdata_in[7:4]))
        else $error("nibble order wrong");
    a_dir_load: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE4
        phase == nsd_pkg::NSD_Q4 && is_dirl && dsel == 3'h6 |=> dir_b_out == $past(wreg_out))
        else $error("direction load wrong");
    a_dir_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE4
        !(phase == nsd_pkg::NSD_Q4 && is_dirl) |=> $stable(dir_a_out) && $stable(dir_c_out))
        else $error("direction register changed without load");
    a_cycle_four: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE5
        done_out |=> !done_out [*3] ##1 done_out)
        else $error("instruction cycle not four clocks");
    a_flags_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE6
        ##1 flags_out == $past(flags_in))
        else $error("status flags altered");
    a_one_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE6
        file_we_out |-> done_out ##1 !file_we_out)
        else $error("write not within one cycle");

    // named steps shared by the checks below
    sequence s_q4_swap_to_f;
        phase == nsd_pkg::NSD_Q4 && is_swap && st_ff.ir[nsd_pkg::NSD_DBIT];
    endsequence
    sequence s_q4_dir_load;
        phase == nsd_pkg::NSD_Q4 && is_dirl;
    endsequence
    sequence s_slot_taken;
        phase == nsd_pkg::NSD_Q1;
    endsequence
    sequence s_three_quiet;
        !done_out [*3];
    endsequence

    // a write goes to the register that supplied the operand
    a_write_address: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE3
        s_q4_swap_to_f |=> file_addr_out == $past(st_ff.ir[4:0]))
        else $error("write address is not the source register");
    // no file write unless a swap names the file register
    a_write_only_swap: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE2
        !(phase == nsd_pkg::NSD_Q4 && is_swap && st_ff.ir[nsd_pkg::NSD_DBIT]) |=> !file_we_out)
        else $error("file write without a swap to the file register");
    // the address is loaded only in the second quarter
    a_addr_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE3
        phase != nsd_pkg::NSD_Q2 |=> $stable(file_addr_out))
        else $error("file address moved outside the second quarter");
    // the working register moves only on a swap to it
    a_wreg_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE3
        !(phase == nsd_pkg::NSD_Q4 && is_swap && !st_ff.ir[nsd_pkg::NSD_DBIT])
        |=> $stable(wreg_out))
        else $error("working register changed without a swap to it");

    // the first and last selectors each load their own direction register and no other
    a_dir_first: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE4
        s_q4_dir_load ##0 dsel == nsd_pkg::NSD_DIR_FIRST
        |=> dir_a_out == $past(wreg_out) && $stable(dir_b_out) && $stable(dir_c_out))
        else $error("first direction register load wrong");
    a_dir_last: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE4
        s_q4_dir_load ##0 dsel == nsd_pkg::NSD_DIR_LAST
        |=> dir_c_out == $past(wreg_out) && $stable(dir_a_out) && $stable(dir_b_out))
        else $error("last direction register load wrong");
    // a refused selector leaves every direction register alone
    a_dir_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE4
        phase == nsd_pkg::NSD_Q4 && (st_ff.ir & nsd_pkg::NSD_DIRL_MASK) == nsd_pkg::NSD_DIRL_CODE
        && dsel < nsd_pkg::NSD_DIR_FIRST |=> $stable(dir_a_out) && $stable(dir_b_out)
            && $stable(dir_c_out))
        else $error("refused selector changed a direction register");
    // a direction load never writes the file or working register
    a_dir_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE6
        s_q4_dir_load |=> !file_we_out && $stable(wreg_out))
        else $error("direction load touched another register");

    // the end-of-cycle marker lines up with the four-quarter slot
    a_done_quarter: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE5
        done_out |-> phase == nsd_pkg::NSD_Q1)
        else $error("cycle marker out of step with the quarters");
    a_slot_length: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE5
        s_slot_taken |=> s_three_quiet ##1 done_out)
        else $error("instruction not finished within its slot");
endmodule // nsd_exec

// ==== verification/nsd_exec_tb.sv ====
// testbench: back-to-back instruction stream checked against a behavioural model
`timescale 1ns/1ps
module nibble_swap_and_direction_load_exec_tb_top;
    // design inputs, all given a value at time zero
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [11:0] instr_in = 12'h000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [2:0] flags_in = 3'h0;
    // design outputs
    logic file_we_out, done_out;
    logic [4:0] file_addr_out;
    logic [7:0] file_wdata_out, wreg_out, dir_a_out, dir_b_out, dir_c_out;
    logic [2:0] flags_out;
    // model state and bookkeeping
    int err_count = 0;
    int comparisons = 0;
    int w = 0;
    int dir[3] = '{255, 255, 255};
    logic [11:0] pq[$];
    logic [7:0] rq[$];
    logic [11:0] ins;
    int r;
    logic [2:0] pf = 3'h0; // flags driven for the slot before
 
    nsd_exec nsd_exec_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
        .file_rdata_in(file_rdata_in), .flags_in(flags_in), .file_we_out(file_we_out),
        .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out), .wreg_out(wreg_out),
        .dir_a_out(dir_a_out), .dir_b_out(dir_b_out), .dir_c_out(dir_c_out),
        .flags_out(flags_out), .done_out(done_out));

    // 250 MHz clock
    initial forever #2 clk_in = ~clk_in;

    // one comparison, reported at once on mismatch
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // one four-clock slot: drive a word at the last-quarter edge, then check the slot before it
    task automatic step(input logic [11:0] i, input logic [7:0] rd);
        logic [11:0] p;
        logic [7:0] s;
        logic [2:0] f;
        logic we;
        logic had;
        f = 3'($urandom);
        had = pq.size() != 0;
        instr_in <= i;
        file_rdata_in <= rd;
        flags_in <= f;
        // results of the slot before stand from this edge to the next one
        @(negedge clk_in);
        if (had)
        begin
            p = pq.pop_front();
            s = rq.pop_front();
            s = {s[3:0], s[7:4]};
            we = ((p & 12'hFC0) == 12'h380) && p[5];
            if (((p & 12'hFC0) == 12'h380) && !p[5]) w = s;
            if (((p & 12'hFF8) == 12'h000) && p[2:0] >= 3'd5) dir[p[2:0] - 5] = w;
            chk("file_we", {7'h0, we}, {7'h0, file_we_out});
            if (we) chk("wdata", s, file_wdata_out);
            if (we) chk("addr", {3'h0, p[4:0]}, {3'h0, file_addr_out});
            chk("wreg", 8'(w), wreg_out);
            chk("dir_a", 8'(dir[0]), dir_a_out);
            chk("dir_b", 8'(dir[1]), dir_b_out);
            chk("dir_c", 8'(dir[2]), dir_c_out);
            chk("flags", {5'h0, pf}, {5'h0, flags_out});
            chk("done", 8'h01, {7'h0, done_out});
        end
        pf = f;
        @(posedge clk_in);
        @(negedge clk_in);
        if (had)
        begin
            chk("done_end", 8'h00, {7'h0, done_out});
            chk("we_end", 8'h00, {7'h0, file_we_out});
        end
        repeat (3) @(posedge clk_in);
        pq.push_back(i);
        rq.push_back(rd);
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'hddfb94e8));
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        step(12'h388, 8'hA5);
        step(12'h3A8, 8'h3C);
        $display("test swap done");
        for (int k = 0; k < 8; k++)
        begin
            step(12'h380 | 12'(k), 8'(k * 37 + 11));
            step(12'(k), 8'h00);
        end
        $display("test direction load done");
        for (int n = 0; n < 300; n++)
        begin
            r = int'($urandom >> 1);
            ins = (r % 3 == 0) ? {6'b001110, 6'(r >> 8)} : 12'(r >> 8);
            if (r % 3 == 1) ins = 12'((r >> 8) & 7);
            step(ins, 8'($urandom));
        end
        step(12'h000, 8'h00);
        $display("test random stream done");
        end_of_test();
    end

    // watchdog well past the expected run length
    initial
    begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule // nibble_swap_and_direction_load_exec_tb_top
